/* src/rscd_pkg.sv */
package rscd_pkg;

    // ********************************************************
    // Three-level strap codes
    // ********************************************************
    localparam logic [1:0] RSCD_LVL_LOW  = 2'h0;
    localparam logic [1:0] RSCD_LVL_MID  = 2'h1;
    localparam logic [1:0] RSCD_LVL_HIGH = 2'h2;
    localparam logic [1:0] RSCD_LVL_RSV  = 2'h3;

    // ********************************************************
    // Decoded setting encodings
    // ********************************************************
    localparam logic [1:0] RSCD_DE_0DB      = 2'h0;
    localparam logic [1:0] RSCD_DE_M2DB     = 2'h1;
    localparam logic [1:0] RSCD_EQ_ADAPTIVE = 2'h0;
    localparam logic [1:0] RSCD_EQ_FIX_7P5  = 2'h1;
    localparam logic [1:0] RSCD_EQ_FIX_14   = 2'h2;
    localparam logic       RSCD_TERM_AUTO   = 1'h0;
    localparam logic       RSCD_TERM_NONE   = 1'h1;

    // ********************************************************
    // Values after reset and power-down
    // ********************************************************
    localparam logic [1:0] RSCD_DE_RESET   = RSCD_DE_0DB;
    localparam logic [1:0] RSCD_EQ_RESET   = RSCD_EQ_ADAPTIVE;
    localparam logic [1:0] RSCD_LVL_RESET  = RSCD_LVL_MID;
    localparam logic       RSCD_TERM_RESET = RSCD_TERM_AUTO;

    // ********************************************************
    // Synchroniser layout
    // ********************************************************
    localparam int RSCD_NUM_STRAPS = 4;
    localparam int RSCD_SYNC_BITS  = 5 + 2 * RSCD_NUM_STRAPS;
    localparam int RSCD_IX_OE      = 0;
    localparam int RSCD_IX_SIGEN   = 1;
    localparam int RSCD_IX_MODE    = 2;
    localparam int RSCD_IX_ADDRHI  = 3;
    localparam int RSCD_IX_CLKOK   = 4;
    localparam int RSCD_IX_STRAP   = 5;
    localparam int RSCD_ST_DEEMPH  = 0;
    localparam int RSCD_ST_EQ      = 1;
    localparam int RSCD_ST_TERM    = 2;
    localparam int RSCD_ST_SWAP    = 3;

    typedef enum {RSCD_OFF, RSCD_SAMPLE, RSCD_RUN} rscd_state_e;

endpackage

/* src/rscd_tri_level.sv */
`timescale 1ns/1ns
module rscd_tri_level
    import rscd_pkg::*;
(
    input  wire logic       above_low,
    input  wire logic       above_high,
    output logic      [1:0] level_code
);

    // Two comparator bits to one level code; high-but-not-low decodes to reserved
    always_comb begin
        case ({above_high, above_low})
            2'b00:   level_code = RSCD_LVL_LOW;
            2'b01:   level_code = RSCD_LVL_MID;
            2'b11:   level_code = RSCD_LVL_HIGH;
            default: level_code = RSCD_LVL_RSV;
        endcase
    end

endmodule

/* src/rscd_strap_decoder.sv */
`timescale 1ns/1ns
module rscd_strap_decoder
    import rscd_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       operation_enable_pin,
    input  wire logic       signal_detect_enable,
    input  wire logic       control_mode_select,
    input  wire logic       addr_high_bit_pin,
    input  wire logic       input_clock_valid,
    input  wire logic       deemphasis_strap_above_low,
    input  wire logic       deemphasis_strap_above_high,
    input  wire logic       equalizer_strap_addr_low_above_low,
    input  wire logic       equalizer_strap_addr_low_above_high,
    input  wire logic       output_termination_strap_above_low,
    input  wire logic       output_termination_strap_above_high,
    input  wire logic       lane_swap_polarity_strap_above_low,
    input  wire logic       lane_swap_polarity_strap_above_high,
    input  wire logic [1:0] bus_deemphasis_cfg,
    input  wire logic [1:0] bus_equalizer_cfg,
    input  wire logic       rate_above_2g,
    input  wire logic       retimer_mode,
    output logic            power_down,
    output logic            config_reset_pulse,
    output logic            standby,
    output logic            signal_detect_active,
    output logic            input_term_connected,
    output logic            bus_control_mode,
    output logic      [1:0] deemphasis_sel,
    output logic      [1:0] equalizer_sel,
    output logic            tx_term_enable,
    output logic            tx_term_mode,
    output logic            rx_lane_swap,
    output logic            rx_polarity_swap,
    output logic            bus_addr_bit1,
    output logic            bus_addr_bit2
);

    // ********************************************************
    // Pin synchronisers
    // ********************************************************
    logic [RSCD_SYNC_BITS-1:0] pin_raw;
    logic [RSCD_SYNC_BITS-1:0] pin_meta_reg;
    logic [RSCD_SYNC_BITS-1:0] pin_sync_reg;
    logic [1:0]                strap_code [RSCD_NUM_STRAPS];

    assign pin_raw = {lane_swap_polarity_strap_above_high, lane_swap_polarity_strap_above_low,
                      output_termination_strap_above_high, output_termination_strap_above_low,
                      equalizer_strap_addr_low_above_high, equalizer_strap_addr_low_above_low,
                      deemphasis_strap_above_high, deemphasis_strap_above_low,
                      input_clock_valid, addr_high_bit_pin, control_mode_select,
                      signal_detect_enable, operation_enable_pin};

    // Two stages; reset to zero so the enable reads low until seen high
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pin_meta_reg <= '0;
            pin_sync_reg <= '0;
        end else begin
            pin_meta_reg <= pin_raw;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // One level decoder per strap, fed only from the second stage
    generate
        for (genvar s = 0; s < RSCD_NUM_STRAPS; s++) begin : g_strap
            rscd_tri_level u_level (
                .above_low  (pin_sync_reg[RSCD_IX_STRAP + 2 * s]),
                .above_high (pin_sync_reg[RSCD_IX_STRAP + 2 * s + 1]),
                .level_code (strap_code[s])
            );
        end
    endgenerate

    logic oe_sync;
    logic signal_detect_enable_sync;
    logic clk_ok_sync;
    assign oe_sync     = pin_sync_reg[RSCD_IX_OE];
    assign signal_detect_enable_sync = pin_sync_reg[RSCD_IX_SIGEN];
    assign clk_ok_sync = pin_sync_reg[RSCD_IX_CLKOK];

    // ********************************************************
    // Power state and strap capture
    // ********************************************************
    rscd_state_e state_reg;
    rscd_state_e state_next;
    logic        cap_mode_reg;
    logic        cap_mode_next;
    logic [1:0]  cap_de_reg;
    logic [1:0]  cap_de_next;
    logic [1:0]  cap_eq_reg;
    logic [1:0]  cap_eq_next;
    logic [1:0]  cap_term_reg;
    logic [1:0]  cap_term_next;
    logic [1:0]  cap_swap_reg;
    logic [1:0]  cap_swap_next;
    logic        cap_a1_reg;
    logic        cap_a1_next;
    logic        cap_a2_reg;
    logic        cap_a2_next;

    // Straps are sampled once per power-up so a noisy pin cannot retune a live link
    always_comb begin
        state_next    = state_reg;
        cap_mode_next = cap_mode_reg;
        cap_de_next   = cap_de_reg;
        cap_eq_next   = cap_eq_reg;
        cap_term_next = cap_term_reg;
        cap_swap_next = cap_swap_reg;
        cap_a1_next   = cap_a1_reg;
        cap_a2_next   = cap_a2_reg;
        case (state_reg)
            RSCD_OFF: begin
                if (oe_sync) begin
                    state_next = RSCD_SAMPLE;
                end
            end
            RSCD_SAMPLE: begin
                state_next    = RSCD_RUN;
                cap_mode_next = pin_sync_reg[RSCD_IX_MODE];
                cap_de_next   = strap_code[RSCD_ST_DEEMPH];
                cap_eq_next   = strap_code[RSCD_ST_EQ];
                cap_term_next = strap_code[RSCD_ST_TERM];
                cap_swap_next = strap_code[RSCD_ST_SWAP];
                cap_a1_next   = pin_sync_reg[RSCD_IX_STRAP + 2 * RSCD_ST_EQ + 1];
                cap_a2_next   = pin_sync_reg[RSCD_IX_ADDRHI];
            end
            RSCD_RUN: begin
                if (!oe_sync) begin
                    state_next = RSCD_OFF;
                end
            end
            default: state_next = RSCD_OFF;
        endcase
        // Falling enable wipes everything captured
        if (!oe_sync) begin
            cap_mode_next = 1'h0;
            cap_de_next   = RSCD_LVL_RESET;
            cap_eq_next   = RSCD_LVL_RESET;
            cap_term_next = RSCD_LVL_RESET;
            cap_swap_next = RSCD_LVL_RESET;
            cap_a1_next   = 1'h0;
            cap_a2_next   = 1'h0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg    <= RSCD_OFF;
            cap_mode_reg <= 1'h0;
            cap_de_reg   <= RSCD_LVL_RESET;
            cap_eq_reg   <= RSCD_LVL_RESET;
            cap_term_reg <= RSCD_LVL_RESET;
            cap_swap_reg <= RSCD_LVL_RESET;
            cap_a1_reg   <= 1'h0;
            cap_a2_reg   <= 1'h0;
        end else begin
            state_reg    <= state_next;
            cap_mode_reg <= cap_mode_next;
            cap_de_reg   <= cap_de_next;
            cap_eq_reg   <= cap_eq_next;
            cap_term_reg <= cap_term_next;
            cap_swap_reg <= cap_swap_next;
            cap_a1_reg   <= cap_a1_next;
            cap_a2_reg   <= cap_a2_next;
        end
    end

    // ********************************************************
    // Decoded settings
    // ********************************************************
    logic       pd_reg,      pd_next;
    logic       crst_reg,    crst_next;
    logic       stby_reg,    stby_next;
    logic       sd_reg,      sd_next;
    logic       iterm_reg,   iterm_next;
    logic       bmode_reg,   bmode_next;
    logic [1:0] de_reg,      de_next;
    logic [1:0] eq_reg,      eq_next;
    logic       tterm_reg,   tterm_next;
    logic       tmode_reg,   tmode_next;
    logic       lswap_reg,   lswap_next;
    logic       pswap_reg,   pswap_next;
    logic       a1_reg,      a1_next;
    logic       a2_reg,      a2_next;
    logic       running;

    assign running = (state_reg == RSCD_RUN);

    always_comb begin
        pd_next    = !running;
        crst_next  = running && !oe_sync;
        sd_next    = running && signal_detect_enable_sync;
        stby_next  = running && signal_detect_enable_sync && !clk_ok_sync;
        iterm_next = !stby_next;
        bmode_next = running && cap_mode_reg;
        a1_next    = running && cap_mode_reg && cap_a1_reg;
        a2_next    = running && cap_mode_reg && cap_a2_reg;
        // Bus values only count in control-bus mode; strap mode ignores them
        if (bmode_next) begin
            de_next = bus_deemphasis_cfg;
            eq_next = bus_equalizer_cfg;
        end else begin
            de_next = (cap_de_reg == RSCD_LVL_LOW) ? RSCD_DE_M2DB : RSCD_DE_0DB;
            case (cap_eq_reg)
                RSCD_LVL_LOW:  eq_next = RSCD_EQ_FIX_7P5;
                RSCD_LVL_HIGH: eq_next = RSCD_EQ_FIX_14;
                default:       eq_next = RSCD_EQ_ADAPTIVE;
            endcase
        end
        // Low is reserved and falls back to automatic, like a floating pin
        tmode_next = (cap_term_reg == RSCD_LVL_HIGH) ? RSCD_TERM_NONE : RSCD_TERM_AUTO;
        tterm_next = running && (tmode_next == RSCD_TERM_AUTO) && rate_above_2g;
        lswap_next = running && (cap_swap_reg == RSCD_LVL_LOW);
        pswap_next = running && (cap_swap_reg == RSCD_LVL_HIGH) && retimer_mode;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pd_reg    <= 1'h1;
            crst_reg  <= 1'h0;
            stby_reg  <= 1'h0;
            sd_reg    <= 1'h0;
            iterm_reg <= 1'h1;
            bmode_reg <= 1'h0;
            de_reg    <= RSCD_DE_RESET;
            eq_reg    <= RSCD_EQ_RESET;
            tterm_reg <= 1'h0;
            tmode_reg <= RSCD_TERM_RESET;
            lswap_reg <= 1'h0;
            pswap_reg <= 1'h0;
            a1_reg    <= 1'h0;
            a2_reg    <= 1'h0;
        end else begin
            pd_reg    <= pd_next;
            crst_reg  <= crst_next;
            stby_reg  <= stby_next;
            sd_reg    <= sd_next;
            iterm_reg <= iterm_next;
            bmode_reg <= bmode_next;
            de_reg    <= de_next;
            eq_reg    <= eq_next;
            tterm_reg <= tterm_next;
            tmode_reg <= tmode_next;
            lswap_reg <= lswap_next;
            pswap_reg <= pswap_next;
            a1_reg    <= a1_next;
            a2_reg    <= a2_next;
        end
    end

    // Outputs straight from the flops
    assign power_down           = pd_reg;
    assign config_reset_pulse   = crst_reg;
    assign standby              = stby_reg;
    assign signal_detect_active = sd_reg;
    assign input_term_connected = iterm_reg;
    assign bus_control_mode     = bmode_reg;
    assign deemphasis_sel       = de_reg;
    assign equalizer_sel        = eq_reg;
    assign tx_term_enable       = tterm_reg;
    assign tx_term_mode         = tmode_reg;
    assign rx_lane_swap         = lswap_reg;
    assign rx_polarity_swap     = pswap_reg;
    assign bus_addr_bit1        = a1_reg;
    assign bus_addr_bit2        = a2_reg;

endmodule

/* bench/rscd_strap_model.sv */
`timescale 1ns/1ns
module rscd_strap_model
    import rscd_pkg::*;
(
    input  wire logic [1:0] lvl_de,
    input  wire logic [1:0] lvl_eq,
    input  wire logic [1:0] lvl_term,
    input  wire logic [1:0] lvl_swap,
    input  wire logic       mode_bus,
    input  wire logic       addr_bit2,
    output logic      [3:0] above_low,
    output logic      [3:0] above_high,
    output logic            addr_high_bit_pin
);
    // ****************************************
    // Board straps seen through two comparators
    // ****************************************
    function automatic logic [1:0] cmp(input logic [1:0] code);
        return {code == RSCD_LVL_HIGH || code == RSCD_LVL_RSV, code == RSCD_LVL_MID || code == RSCD_LVL_HIGH};
    endfunction

    // Bus mode drives the equaliser pin two-level only; open address pin reads low
    always_comb begin
        logic [1:0] eq_code;
        eq_code = mode_bus ? (lvl_eq[1] ? RSCD_LVL_HIGH : RSCD_LVL_LOW) : lvl_eq;
        {above_high[RSCD_ST_DEEMPH], above_low[RSCD_ST_DEEMPH]} = cmp(lvl_de);
        {above_high[RSCD_ST_EQ], above_low[RSCD_ST_EQ]} = cmp(eq_code);
        {above_high[RSCD_ST_TERM], above_low[RSCD_ST_TERM]} = cmp(lvl_term);
        {above_high[RSCD_ST_SWAP], above_low[RSCD_ST_SWAP]} = cmp(lvl_swap);
        addr_high_bit_pin = mode_bus & addr_bit2;
    end
endmodule

/* bench/rscd_strap_chk.sv */
`timescale 1ns/1ns
module rscd_strap_chk
    import rscd_pkg::*;
(
    input wire logic       clk,
    input wire logic       reset,
    input wire logic       operation_enable_pin,
    input wire logic       retimer_mode,
    input wire logic       power_down,
    input wire logic       config_reset_pulse,
    input wire logic       standby,
    input wire logic       signal_detect_active,
    input wire logic       input_term_connected,
    input wire logic       bus_control_mode,
    input wire logic [1:0] deemphasis_sel,
    input wire logic [1:0] equalizer_sel,
    input wire logic       tx_term_enable,
    input wire logic       tx_term_mode,
    input wire logic       rx_lane_swap,
    input wire logic       rx_polarity_swap,
    input wire logic       bus_addr_bit1,
    input wire logic       bus_addr_bit2
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // ****************************************
    // Enable sequences
    // ****************************************
    sequence s_enable_up;
        $rose(operation_enable_pin) ##1 operation_enable_pin [*6];
    endsequence
    sequence s_drop;
        !power_down && $fell(operation_enable_pin);
    endsequence

    run_release_a: assert property (s_enable_up |-> !power_down)
        else $error("power_down still high after enable");
    off_hold_a: assert property (!operation_enable_pin [*5] |-> power_down)
        else $error("power_down low with enable low");
    pulse_single_a: assert property (config_reset_pulse |=> !config_reset_pulse)
        else $error("reset pulse longer than one cycle");
    pulse_cause_a: assert property (config_reset_pulse |=> $rose(power_down))
        else $error("reset pulse without power-down entry");
    drop_pulse_a: assert property (s_drop |-> ##[1:4] config_reset_pulse)
        else $error("no reset pulse after enable fell");
    off_default_a: assert property (power_down && $past(power_down) |-> !bus_control_mode && !tx_term_enable
        && deemphasis_sel == RSCD_DE_RESET && equalizer_sel == RSCD_EQ_RESET && tx_term_mode == RSCD_TERM_RESET)
        else $error("settings not at defaults in power-down");
    term_connect_a: assert property (!signal_detect_active |-> input_term_connected && !standby)
        else $error("termination dropped with detector off");
    standby_link_a: assert property (standby |-> signal_detect_active && !input_term_connected)
        else $error("standby inconsistent with detector");
    cfg_hold_a: assert property (!power_down && !$past(power_down) |-> $stable(tx_term_mode)
        && $stable(rx_lane_swap) && $stable(bus_control_mode) && $stable(bus_addr_bit1) && $stable(bus_addr_bit2))
        else $error("captured setting changed while running");
    addr_strap_a: assert property (!bus_control_mode |-> !bus_addr_bit1 && !bus_addr_bit2)
        else $error("address bits set in strap mode");
    term_auto_a: assert property (tx_term_enable |-> tx_term_mode == RSCD_TERM_AUTO)
        else $error("termination on outside automatic mode");
    polarity_ret_a: assert property (rx_polarity_swap |-> $past(retimer_mode) && !rx_lane_swap)
        else $error("polarity swap outside retimer mode");
endmodule

bind rscd_strap_decoder rscd_strap_chk rscd_strap_chk_inst (.clk, .reset, .operation_enable_pin, .retimer_mode,
    .power_down, .config_reset_pulse, .standby, .signal_detect_active, .input_term_connected, .bus_control_mode,
    .deemphasis_sel, .equalizer_sel, .tx_term_enable, .tx_term_mode, .rx_lane_swap, .rx_polarity_swap,
    .bus_addr_bit1, .bus_addr_bit2);

/* bench/rscd_strap_decoder_tb_top.sv */
`timescale 1ns/1ns
module rscd_strap_decoder_tb_top
    import rscd_pkg::*;
;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        oe = 1'b0, sigen = 1'b0, cv = 1'b0, rate = 1'b0, ret = 1'b0, mode = 1'b0, a2 = 1'b0;
    logic [1:0]  lv [4] = '{default: 2'h1};
    logic [1:0]  c_lv [4];
    logic [1:0]  bde = 2'h0, beq = 2'h0, des, eqs;
    logic [3:0]  ab_lo, ab_hi;
    logic        addr_pin, pd, crp, stb, sda, itc, bcm, te, tm, ls, ps, a1o, a2o, c_mode, c_a2;
    logic [14:0] outs;
    int          err_total = 0, n_checks = 0, seed = 26, pulses = 0, p0;

    always #4 clk = ~clk;
    assign outs = {pd, stb, sda, itc, bcm, a1o, a2o, des, eqs, te, tm, ls, ps};

    rscd_strap_model rscd_strap_model_inst (.lvl_de(lv[0]), .lvl_eq(lv[1]), .lvl_term(lv[2]), .lvl_swap(lv[3]),
        .mode_bus(mode), .addr_bit2(a2), .above_low(ab_lo), .above_high(ab_hi), .addr_high_bit_pin(addr_pin));

    rscd_strap_decoder rscd_strap_decoder_inst (.clk(clk), .reset(reset), .operation_enable_pin(oe),
        .signal_detect_enable(sigen), .control_mode_select(mode), .addr_high_bit_pin(addr_pin),
        .input_clock_valid(cv), .deemphasis_strap_above_low(ab_lo[0]), .deemphasis_strap_above_high(ab_hi[0]),
        .equalizer_strap_addr_low_above_low(ab_lo[1]), .equalizer_strap_addr_low_above_high(ab_hi[1]),
        .output_termination_strap_above_low(ab_lo[2]), .output_termination_strap_above_high(ab_hi[2]),
        .lane_swap_polarity_strap_above_low(ab_lo[3]), .lane_swap_polarity_strap_above_high(ab_hi[3]),
        .bus_deemphasis_cfg(bde), .bus_equalizer_cfg(beq), .rate_above_2g(rate), .retimer_mode(ret),
        .power_down(pd), .config_reset_pulse(crp), .standby(stb), .signal_detect_active(sda),
        .input_term_connected(itc), .bus_control_mode(bcm), .deemphasis_sel(des), .equalizer_sel(eqs),
        .tx_term_enable(te), .tx_term_mode(tm), .rx_lane_swap(ls), .rx_polarity_swap(ps),
        .bus_addr_bit1(a1o), .bus_addr_bit2(a2o));

    // Count reset pulses seen on the output
    always @(posedge clk) begin
        if (crp === 1'b1) begin
            pulses <= pulses + 1;
        end
    end

    // ****************************************
    // Reference model of the decoded outputs
    // ****************************************
    function automatic logic [14:0] expv(input bit run);
        logic [1:0] de, eq;
        logic       tmv;
        if (!run) begin
            return 15'h4800;
        end
        de = c_mode ? bde : (c_lv[0] == 2'h0 ? RSCD_DE_M2DB : RSCD_DE_0DB);
        eq = c_mode ? beq : (c_lv[1] == 2'h0 ? RSCD_EQ_FIX_7P5 : c_lv[1] == 2'h2 ? RSCD_EQ_FIX_14 : RSCD_EQ_ADAPTIVE);
        tmv = c_lv[2] == 2'h2;
        return {1'b0, sigen && !cv, sigen, !(sigen && !cv), c_mode, c_mode && c_lv[1][1], c_mode && c_a2,
                de, eq, !tmv && rate, tmv, c_lv[3] == 2'h0, c_lv[3] == 2'h2 && ret};
    endfunction

    task automatic chk(input string what, input logic [14:0] seen, input logic [14:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Random pins; strap changes while running must be ignored
    task automatic rnd();
        logic [31:0] r;
        @(posedge clk);
        r = $random(seed);
        {beq, bde, ret, rate, cv, sigen} <= r[7:0];
        for (int k = 0; k < 4; k++) begin
            lv[k] <= r[8+2*k +: 2];
        end
        mode <= r[16];
        a2 <= r[17];
    endtask

    task automatic results();
        if (err_total == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ****************************************
    // Power cycles with random straps
    // ****************************************
    initial begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        for (int i = 0; i < 48; i++) begin
            rnd();
            repeat (4) @(posedge clk);
            oe <= 1'b1;
            c_lv = lv;
            c_mode = mode;
            c_a2 = a2;
            repeat (8) @(posedge clk);
            @(negedge clk) chk("outputs after enable", outs, expv(1'b1));
            rnd();
            repeat (5) @(posedge clk);
            @(negedge clk) chk("outputs while running", outs, expv(1'b1));
            p0 = pulses;
            @(posedge clk) oe <= 1'b0;
            repeat (8) @(posedge clk);
            @(negedge clk) chk("outputs in power-down", outs, expv(1'b0));
            chk("reset pulses", 15'(pulses - p0), 15'h1);
        end
        results();
    end

    // Hang guard, well beyond the expected run of about 1350 cycles
    initial begin
        repeat (4000) @(posedge clk);
        err_total++;
        results();
    end
endmodule
